// >>> rtl/mem_timing_pkg.sv
package mem_timing_pkg;

  // ************************************************************
  // clock and unit conversion
  // ************************************************************
  localparam int CLK_PERIOD_PS = 40000;  // 25 mhz system clock

  // least time in ps to cycles, rounded up, never below one
  function automatic int ps_to_cyc(input int t_ps);
    int c;
    c = (t_ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction : ps_to_cyc

  function automatic int max2(input int a, input int b);
    return (a > b) ? a : b;
  endfunction : max2

  // ************************************************************
  // printed limits, in their own units
  // ************************************************************
  localparam int MODE_SET_SPACING_NCK        = 4;
  localparam int MODE_UPDATE_DELAY_NCK       = 12;
  localparam int MODE_UPDATE_DELAY_PS        = 15000;
  localparam int COLUMN_CMD_SPACING_NCK      = 4;
  localparam int READ_TO_PRECHARGE_NCK       = 4;
  localparam int READ_TO_PRECHARGE_PS        = 7500;
  localparam int WRITE_TO_READ_NCK           = 4;
  localparam int WRITE_TO_READ_PS            = 7500;
  localparam int WRITE_RECOVERY_PS           = 15000;
  localparam int PRECHARGE_PERIOD_PS         = 15000;
  localparam int PURPOSE_REG_RECOVERY_NCK    = 1;
  localparam int ACTIVATE_SPACING_NCK        = 4;
  localparam int ACTIVATE_SPACING_PS         = 10000;
  localparam int FOUR_ACTIVATE_WINDOW_PS     = 50000;
  localparam int INITIAL_CALIBRATION_NCK     = 512;
  localparam int LONG_CALIBRATION_NCK        = 256;
  localparam int SHORT_CALIBRATION_NCK       = 64;
  localparam int LOOP_LOCK_NCK               = 512;
  localparam int REFRESH_CYCLE_PS            = 160000;
  localparam int EXIT_EXTRA_PS               = 10000;
  localparam int EXIT_MIN_NCK                = 5;
  localparam int CLOCK_VALID_NCK             = 5;
  localparam int CLOCK_VALID_PS              = 10000;
  localparam int POWERDOWN_EXIT_NCK          = 3;
  localparam int POWERDOWN_EXIT_PS           = 7500;
  localparam int POWERDOWN_EXIT_LOCKED_NCK   = 10;
  localparam int POWERDOWN_EXIT_LOCKED_PS    = 24000;
  localparam int CKE_MIN_WIDTH_NCK           = 3;
  localparam int CKE_MIN_WIDTH_PS            = 7500;
  localparam int POWERDOWN_MAX_REFI          = 9;
  localparam int REFRESH_INTERVAL_PS         = 7800000;
  localparam int TERM_HOLD_SHORT_NCK         = 4;
  localparam int TERM_HOLD_LONG_NCK          = 6;
  localparam int LEVEL_FIRST_STROBE_WAIT_NCK = 40;
  localparam int LEVEL_STROBE_DRIVE_WAIT_NCK = 25;

  // ************************************************************
  // derived cycle counts at the system clock
  // ************************************************************
  localparam int MODE_SET_SPACING_CYC     = MODE_SET_SPACING_NCK;
  localparam int MODE_UPDATE_DELAY_CYC    =
    max2(MODE_UPDATE_DELAY_NCK, ps_to_cyc(MODE_UPDATE_DELAY_PS));
  localparam int COLUMN_CMD_SPACING_CYC   = COLUMN_CMD_SPACING_NCK;
  localparam int READ_TO_PRECHARGE_CYC    =
    max2(READ_TO_PRECHARGE_NCK, ps_to_cyc(READ_TO_PRECHARGE_PS));
  localparam int WRITE_TO_READ_CYC        =
    max2(WRITE_TO_READ_NCK, ps_to_cyc(WRITE_TO_READ_PS));
  localparam int WRITE_RECOVERY_CYC       = ps_to_cyc(WRITE_RECOVERY_PS);
  localparam int AUTOPRECHARGE_WRITE_TOTAL_CYC =
    WRITE_RECOVERY_CYC + ps_to_cyc(PRECHARGE_PERIOD_PS);
  localparam int PURPOSE_REG_RECOVERY_CYC = PURPOSE_REG_RECOVERY_NCK;
  localparam int ACTIVATE_SPACING_CYC     =
    max2(ACTIVATE_SPACING_NCK, ps_to_cyc(ACTIVATE_SPACING_PS));
  localparam int FOUR_ACTIVATE_WINDOW_CYC = ps_to_cyc(FOUR_ACTIVATE_WINDOW_PS);
  localparam int SELFREFRESH_EXIT_LOCKED_CYC = LOOP_LOCK_NCK;
  localparam int SELFREFRESH_EXIT_UNLOCKED_CYC =
    max2(EXIT_MIN_NCK, ps_to_cyc(REFRESH_CYCLE_PS + EXIT_EXTRA_PS));
  localparam int RESET_EXIT_DELAY_CYC     = SELFREFRESH_EXIT_UNLOCKED_CYC;
  localparam int CKE_MIN_WIDTH_CYC        =
    max2(CKE_MIN_WIDTH_NCK, ps_to_cyc(CKE_MIN_WIDTH_PS));
  localparam int SELFREFRESH_MIN_LOW_CYC  = CKE_MIN_WIDTH_CYC + 1;
  localparam int CLOCK_HOLD_CYC           =
    max2(CLOCK_VALID_NCK, ps_to_cyc(CLOCK_VALID_PS));
  localparam int POWERDOWN_EXIT_DELAY_CYC =
    max2(POWERDOWN_EXIT_NCK, ps_to_cyc(POWERDOWN_EXIT_PS));
  localparam int POWERDOWN_EXIT_LOCKED_CYC =
    max2(POWERDOWN_EXIT_LOCKED_NCK, ps_to_cyc(POWERDOWN_EXIT_LOCKED_PS));
  // longest time, rounded down: 9 refresh intervals
  localparam int POWERDOWN_MAX_CYC =
    (POWERDOWN_MAX_REFI * (REFRESH_INTERVAL_PS / 1000)) / (CLK_PERIOD_PS / 1000);

  localparam int CNT_W = 12;  // wide enough for every gap and for power-down max too
  localparam int PD_W  = 16;

  // ************************************************************
  // command encoding and carriers
  // ************************************************************
  typedef enum logic [3:0] {
    CMD_NOP      = 4'h0,
    CMD_MODE_SET = 4'h1,
    CMD_ACTIVATE = 4'h2,
    CMD_READ     = 4'h3,
    CMD_WRITE    = 4'h4,
    CMD_WRITE_AP = 4'h5,
    CMD_PRECHG   = 4'h6,
    CMD_REFRESH  = 4'h7,
    CMD_CAL_LONG = 4'h8,
    CMD_CAL_SHRT = 4'h9,
    CMD_CAL_INIT = 4'hA,
    CMD_PURPOSE  = 4'hB,
    CMD_LEVEL    = 4'hC
  } mem_cmd_t;

  // request from the user side
  typedef struct packed {
    mem_cmd_t   cmd;
    logic [2:0] bank;
    logic       needs_lock;  // command needs a locked delay loop
    logic       burst8;      // 8-beat write, for termination hold
  } mem_req_t;

  // pins toward the memory
  typedef struct packed {
    mem_cmd_t   cmd;
    logic [2:0] bank;
    logic       cke;
    logic       term_en;
    logic       reset_n;
  } mem_pins_t;

  // power state of the cke sequencer
  typedef enum logic [2:0] {
    PWR_RESET = 3'b000,
    PWR_WAKE  = 3'b001,
    PWR_RUN   = 3'b011,
    PWR_PDN   = 3'b010,
    PWR_SREF  = 3'b110
  } pwr_state_t;

endpackage : mem_timing_pkg

// >>> rtl/gap_timer.sv
// down counter: load a minimum gap, report when it has run out
module gap_timer
  import mem_timing_pkg::*;
(
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_load,
  input  wire logic [CNT_W-1:0] i_value,
  output logic                  o_done
);

  logic [CNT_W-1:0] cnt_reg;  // cycles still to wait

  // a larger pending gap is kept when a shorter one is loaded
  wire logic take = i_load && (i_value > cnt_reg);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_reg <= '0;
    end else if (take) begin
      cnt_reg <= i_value - 1'b1;
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end

  assign o_done = (cnt_reg == '0);

endmodule : gap_timer

// >>> rtl/activate_window.sv
// remembers the last four activations and blocks a fifth inside the window
module activate_window
  import mem_timing_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_act,
  output logic      o_ok
);

  logic [CNT_W-1:0] age_reg [4];  // window time left per slot
  logic [3:0]       busy;

  // a slot is busy while its window is still open
  for (genvar g = 0; g < 4; g++) begin : g_slot
    assign busy[g] = (age_reg[g] != '0);
  end

  // free slot, lowest first
  wire logic [1:0] pick = !busy[0] ? 2'd0 : !busy[1] ? 2'd1 :
                          !busy[2] ? 2'd2 : 2'd3;

  for (genvar g = 0; g < 4; g++) begin : g_age
    always_ff @(posedge i_clk) begin
      if (i_rst) begin
        age_reg[g] <= '0;
      end else if (i_act && pick == 2'(g) && !busy[g]) begin
        age_reg[g] <= CNT_W'(FOUR_ACTIVATE_WINDOW_CYC - 1);
      end else if (busy[g]) begin
        age_reg[g] <= age_reg[g] - 1'b1;
      end
    end
  end

  assign o_ok = (busy != 4'hF);

endmodule : activate_window

// >>> rtl/mem_cmd_sched.sv
module mem_cmd_sched
  import mem_timing_pkg::*;
(
  input  wire logic       I_SYS_CLK,
  input  wire logic       I_SYS_RST,
  input  wire mem_req_t   I_REQ,
  input  wire logic       I_REQ_VALID,
  input  wire logic       I_PDN_REQ,
  input  wire logic       I_SREF_REQ,
  input  wire logic       I_TERM_REQ,
  output mem_pins_t       O_PINS,
  output logic            O_REQ_READY,
  output logic            O_CLK_EN,
  output logic            O_STROBE_DRV_OK,
  output logic            O_STROBE_EDGE_OK
);

  // ************************************************************
  // power sequencing state
  // ************************************************************
  pwr_state_t       pwr_reg, pwr_next;
  logic [PD_W-1:0]  cke_cnt_reg;   // cycles cke has held its level
  logic             cke_reg;
  logic             reset_n_reg;
  logic             clk_en_reg;
  logic [CNT_W-1:0] clk_hold_reg;  // clock kept valid after entry
  logic             sref_seen_reg; // last low phase was selfrefresh
  logic             frozen_exit_reg;

  // ************************************************************
  // request decode
  // ************************************************************
  wire mem_cmd_t cmd      = I_REQ.cmd;
  wire logic     is_mrs   = (cmd == CMD_MODE_SET);
  wire logic     is_level = (cmd == CMD_LEVEL);
  wire logic     is_rd    = (cmd == CMD_READ);
  wire logic     is_wr    = (cmd == CMD_WRITE) || (cmd == CMD_WRITE_AP);
  wire logic     is_col   = is_rd || is_wr;
  wire logic     is_act   = (cmd == CMD_ACTIVATE);
  wire logic     is_pre   = (cmd == CMD_PRECHG);
  wire logic     is_cal   = (cmd == CMD_CAL_LONG) || (cmd == CMD_CAL_SHRT) ||
                            (cmd == CMD_CAL_INIT);
  wire logic     is_mpr   = (cmd == CMD_PURPOSE);

  // ************************************************************
  // gap timers, one per spacing class
  // ************************************************************
  localparam int NT = 9;
  localparam int T_MRD = 0;  // mode set to mode set
  localparam int T_MOD = 1;  // mode set to other
  localparam int T_CCD = 2;  // column to column
  localparam int T_WTR = 3;  // write to read
  localparam int T_RRD = 4;  // activate to activate
  localparam int T_ALL = 5;  // calibration, purpose reg, exits: blocks all
  localparam int T_LCK = 6;  // exits: blocks locked commands
  localparam int T_LVL = 7;  // leveling strobe edge
  localparam int T_DQS = 8;  // leveling strobe drive

  logic [NT-1:0]    t_load;
  logic [CNT_W-1:0] t_val [NT];
  logic [NT-1:0]    t_done;

  for (genvar g = 0; g < NT; g++) begin : g_tmr
    gap_timer u_tmr (
      .i_clk   (I_SYS_CLK),
      .i_rst   (I_SYS_RST),
      .i_load  (t_load[g]),
      .i_value (t_val[g]),
      .o_done  (t_done[g])
    );
  end

  // per-bank precharge hold-off: read and write recovery
  logic [CNT_W-1:0] bank_cnt_reg [8];
  logic [7:0]       bank_ok;
  for (genvar b = 0; b < 8; b++) begin : g_bank
    assign bank_ok[b] = (bank_cnt_reg[b] == '0);
  end

  logic fav_ok;
  wire logic issue;
  activate_window u_faw (
    .i_clk (I_SYS_CLK),
    .i_rst (I_SYS_RST),
    .i_act (issue && is_act),
    .o_ok  (fav_ok)
  );

  // ************************************************************
  // admission check for the pending request
  // ************************************************************
  wire logic run     = (pwr_reg == PWR_RUN) && cke_reg;
  wire logic lock_ok = !I_REQ.needs_lock || t_done[T_LCK];
  wire logic gap_ok  =
    t_done[T_ALL] && lock_ok &&
    (is_mrs ? t_done[T_MRD] : t_done[T_MOD]) &&
    (!is_col || t_done[T_CCD]) &&
    (!is_rd  || t_done[T_WTR]) &&
    (!is_act || (t_done[T_RRD] && fav_ok)) &&
    (!(is_act || is_pre) || bank_ok[I_REQ.bank]);
  wire logic want_low = I_PDN_REQ || I_SREF_REQ;
  assign issue = run && I_REQ_VALID && !want_low && gap_ok &&
                 (cmd != CMD_NOP);

  // ************************************************************
  // timer loads on issue or on power exit
  // ************************************************************
  wire logic exit_now  = (pwr_next == PWR_RUN) && (pwr_reg != PWR_RUN);
  wire logic exit_sref = exit_now && sref_seen_reg;
  wire logic exit_rst  = exit_now && (pwr_reg == PWR_WAKE);

  logic [CNT_W-1:0] all_val;
  logic [CNT_W-1:0] lck_val;
  always_comb begin
    // calibration length by kind, exits by kind; all in cycles
    all_val = '0;
    lck_val = '0;
    if (issue && cmd == CMD_CAL_INIT)
      all_val = CNT_W'(INITIAL_CALIBRATION_NCK + 1);
    else if (issue && cmd == CMD_CAL_LONG)
      all_val = CNT_W'(LONG_CALIBRATION_NCK + 1);
    else if (issue && cmd == CMD_CAL_SHRT)
      all_val = CNT_W'(SHORT_CALIBRATION_NCK + 1);
    else if (issue && is_mpr)
      all_val = CNT_W'(PURPOSE_REG_RECOVERY_CYC + 1);
    else if (exit_rst)
      all_val = CNT_W'(RESET_EXIT_DELAY_CYC);
    else if (exit_sref)
      all_val = CNT_W'(SELFREFRESH_EXIT_UNLOCKED_CYC);
    else if (exit_now)
      all_val = CNT_W'(POWERDOWN_EXIT_DELAY_CYC);
    if (exit_sref)
      lck_val = CNT_W'(SELFREFRESH_EXIT_LOCKED_CYC);
    else if (exit_now && frozen_exit_reg)
      lck_val = CNT_W'(POWERDOWN_EXIT_LOCKED_CYC);
  end

  assign t_load[T_MRD] = issue && is_mrs;
  assign t_val[T_MRD]  = CNT_W'(MODE_SET_SPACING_CYC);
  assign t_load[T_MOD] = issue && (is_mrs || is_level);
  assign t_val[T_MOD]  = CNT_W'(MODE_UPDATE_DELAY_CYC);
  assign t_load[T_CCD] = issue && is_col;
  assign t_val[T_CCD]  = CNT_W'(COLUMN_CMD_SPACING_CYC);
  assign t_load[T_WTR] = issue && is_wr;
  assign t_val[T_WTR]  = CNT_W'(WRITE_TO_READ_CYC);
  assign t_load[T_RRD] = issue && is_act;
  assign t_val[T_RRD]  = CNT_W'(ACTIVATE_SPACING_CYC);
  assign t_load[T_ALL] = (all_val != '0);
  assign t_val[T_ALL]  = all_val;
  assign t_load[T_LCK] = (lck_val != '0);
  assign t_val[T_LCK]  = lck_val;
  assign t_load[T_LVL] = issue && is_level;
  assign t_val[T_LVL]  = CNT_W'(LEVEL_FIRST_STROBE_WAIT_NCK);
  assign t_load[T_DQS] = issue && is_level;
  assign t_val[T_DQS]  = CNT_W'(LEVEL_STROBE_DRIVE_WAIT_NCK);

  // ************************************************************
  // per-bank recovery counters
  // ************************************************************
  for (genvar b = 0; b < 8; b++) begin : g_bcnt
    wire logic hit = issue && (I_REQ.bank == 3'(b));
    wire logic [CNT_W-1:0] val =
      (cmd == CMD_WRITE_AP) ? CNT_W'(AUTOPRECHARGE_WRITE_TOTAL_CYC) :
      (cmd == CMD_WRITE)    ? CNT_W'(WRITE_RECOVERY_CYC) :
      is_rd                 ? CNT_W'(READ_TO_PRECHARGE_CYC) : '0;
    always_ff @(posedge I_SYS_CLK) begin
      if (I_SYS_RST) begin
        bank_cnt_reg[b] <= '0;
      end else if (hit && val > bank_cnt_reg[b]) begin
        bank_cnt_reg[b] <= val - 1'b1;
      end else if (bank_cnt_reg[b] != '0) begin
        bank_cnt_reg[b] <= bank_cnt_reg[b] - 1'b1;
      end
    end
  end

  // ************************************************************
  // cke and power state machine
  // ************************************************************
  wire logic cke_width_ok = (cke_cnt_reg >= PD_W'(CKE_MIN_WIDTH_CYC));
  wire logic sref_low_ok  = (cke_cnt_reg >= PD_W'(SELFREFRESH_MIN_LOW_CYC));
  wire logic pd_expired   = (cke_cnt_reg >= PD_W'(POWERDOWN_MAX_CYC));
  wire logic clk_ready    = (clk_hold_reg == '0);
  wire logic quiet        = t_done[T_ALL] && (&bank_ok);

  always_comb begin
    pwr_next = pwr_reg;
    case (pwr_reg)
      PWR_RESET: begin
        // clock valid before reset exit, then raise cke
        if (clk_ready)
          pwr_next = PWR_WAKE;
      end
      PWR_WAKE: begin
        pwr_next = PWR_RUN;
      end
      PWR_RUN: begin
        if (want_low && cke_width_ok && quiet)
          pwr_next = I_SREF_REQ ? PWR_SREF : PWR_PDN;
      end
      PWR_PDN: begin
        // leave when asked or once the refresh limit is reached
        if ((!I_PDN_REQ || pd_expired) && cke_width_ok && clk_ready)
          pwr_next = PWR_RUN;
      end
      PWR_SREF: begin
        if (!I_SREF_REQ && sref_low_ok && clk_ready)
          pwr_next = PWR_RUN;
      end
      default: pwr_next = PWR_RESET;
    endcase
  end

  wire logic cke_next   = (pwr_next == PWR_RUN);
  wire logic enter_low  = (pwr_reg == PWR_RUN) && (pwr_next != PWR_RUN);

  // state, cke level and its age
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      pwr_reg     <= PWR_RESET;
      cke_reg     <= 1'b0;
      cke_cnt_reg <= '0;
    end else begin
      pwr_reg     <= pwr_next;
      cke_reg     <= cke_next;
      cke_cnt_reg <= (cke_next != cke_reg) ? PD_W'(1) :
                     (&cke_cnt_reg) ? cke_cnt_reg : cke_cnt_reg + 1'b1;
    end
  end

  // clock hold window: after entry and before any exit or reset release
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      clk_hold_reg <= CNT_W'(CLOCK_HOLD_CYC);
      clk_en_reg   <= 1'b1;
    end else if (enter_low) begin
      clk_hold_reg <= CNT_W'(CLOCK_HOLD_CYC);
      clk_en_reg   <= 1'b1;
    end else if (clk_hold_reg != '0) begin
      clk_hold_reg <= clk_hold_reg - 1'b1;
    end
  end

  // remember the kind of low phase for the exit delays
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      sref_seen_reg   <= 1'b0;
      frozen_exit_reg <= 1'b0;
      reset_n_reg     <= 1'b0;
    end else begin
      if (enter_low) begin
        sref_seen_reg   <= I_SREF_REQ;
        frozen_exit_reg <= !I_SREF_REQ;  // slow exit taken for all power-down
      end
      if (clk_ready)
        reset_n_reg <= 1'b1;
    end
  end

  // ************************************************************
  // termination enable hold
  // ************************************************************
  logic [3:0] term_cnt_reg;
  logic       term_reg;
  wire  logic term_hold = (term_cnt_reg != '0);
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      term_reg     <= 1'b0;
      term_cnt_reg <= '0;
    end else begin
      term_reg <= (I_TERM_REQ && run) || term_hold;
      if (issue && is_wr && I_REQ.burst8)
        term_cnt_reg <= 4'(TERM_HOLD_LONG_NCK - 1);
      else if (I_TERM_REQ && !term_reg)
        term_cnt_reg <= 4'(TERM_HOLD_SHORT_NCK - 1);
      else if (term_hold)
        term_cnt_reg <= term_cnt_reg - 1'b1;
    end
  end

  // ************************************************************
  // registered pins
  // ************************************************************
  mem_pins_t pins_reg;
  logic      ready_reg;
  logic      lvl_edge_reg;
  logic      lvl_drv_reg;
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      pins_reg     <= '0;
      ready_reg    <= 1'b0;
      lvl_edge_reg <= 1'b0;
      lvl_drv_reg  <= 1'b0;
    end else begin
      pins_reg.cmd     <= issue ? cmd : CMD_NOP;
      pins_reg.bank    <= I_REQ.bank;
      pins_reg.cke     <= cke_next;
      pins_reg.term_en <= (I_TERM_REQ && run) || term_hold;
      pins_reg.reset_n <= reset_n_reg;
      ready_reg        <= issue;
      lvl_edge_reg     <= t_done[T_LVL];
      lvl_drv_reg      <= t_done[T_DQS];
    end
  end

  assign O_PINS           = pins_reg;
  assign O_REQ_READY      = ready_reg;
  assign O_CLK_EN         = clk_en_reg;
  assign O_STROBE_DRV_OK  = lvl_drv_reg;
  assign O_STROBE_EDGE_OK = lvl_edge_reg;

endmodule : mem_cmd_sched

// >>> dv/mem_cmd_sched_sva.sv
// ************************************************************
// timing checks on the command pins
// ************************************************************
module mem_cmd_sched_sva
  import mem_timing_pkg::*;
(
  input  wire logic      I_SYS_CLK,
  input  wire logic      I_SYS_RST,
  input  wire mem_pins_t O_PINS,
  input  wire logic      O_CLK_EN
);
  timeunit 1ns;
  timeprecision 1ps;
  mem_cmd_t    last_reg;  // last command seen on the pins
  logic [11:0] since_reg; // cycles since it, saturating
  wire         issue = O_PINS.cmd != CMD_NOP;
  wire         col   = O_PINS.cmd inside {CMD_READ, CMD_WRITE, CMD_WRITE_AP};
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_SYS_RST);
  // one counter serves the mode set and calibration gaps
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST || issue) begin
      last_reg  <= I_SYS_RST ? CMD_NOP : O_PINS.cmd;
      since_reg <= I_SYS_RST ? 12'hfff : 12'h001;
    end else if (since_reg != 12'hfff) begin
      since_reg <= since_reg + 12'h001;
    end
  end
  chk_mode_space: assert property (
    issue && O_PINS.cmd == CMD_MODE_SET && last_reg == CMD_MODE_SET |-> since_reg >= 4)
    else $error("mode sets too close");
  chk_mode_update: assert property (
    issue && O_PINS.cmd != CMD_MODE_SET && last_reg == CMD_MODE_SET |-> since_reg >= 12)
    else $error("command too soon after mode set");
  chk_col_space: assert property (col |=> (!col)[*3])
    else $error("column commands too close");
  chk_act_space: assert property (
    O_PINS.cmd == CMD_ACTIVATE |=> (O_PINS.cmd != CMD_ACTIVATE)[*3])
    else $error("activations too close");
  chk_cal_init: assert property (issue && last_reg == CMD_CAL_INIT |-> since_reg >= 512)
    else $error("command during first calibration");
  chk_cal_normal: assert property (
    issue && last_reg inside {CMD_CAL_LONG, CMD_CAL_SHRT}
    |-> since_reg >= ((last_reg == CMD_CAL_LONG) ? 256 : 64))
    else $error("command during calibration");
  chk_cke_width: assert property ($changed(O_PINS.cke) |=> $stable(O_PINS.cke)[*2])
    else $error("cke level too short");
  chk_exit_quiet: assert property ($rose(O_PINS.cke) |-> (!issue)[*3])
    else $error("command too soon after cke rise");
  chk_clock_held: assert property (O_CLK_EN)
    else $error("memory clock stopped");
  cover property (O_PINS.cmd == CMD_CAL_INIT);
  cover property ($fell(O_PINS.cke));
  cover property (col ##4 col);
endmodule : mem_cmd_sched_sva

// >>> dv/mem_dev_model.sv
// ************************************************************
// memory side: flags commands it cannot accept
// ************************************************************
module mem_dev_model
  import mem_timing_pkg::*;
(
  input  wire logic      i_clk,
  input  wire mem_pins_t i_pins,
  output int             o_viol
);
  timeunit 1ns;
  timeprecision 1ps;
  int  busy = 0;         // calibration cycles still running
  int  bank_busy[8];     // write recovery plus precharge left per bank
  wire live = i_pins.cmd != CMD_NOP;
  initial o_viol = 0;
  // count down, then load on the command that occupies the part
  always @(posedge i_clk) begin
    if (busy > 0) busy <= busy - 1;
    foreach (bank_busy[i]) if (bank_busy[i] > 0) bank_busy[i] <= bank_busy[i] - 1;
    if (live && (busy > 0 || i_pins.cke !== 1'b1 || i_pins.reset_n !== 1'b1 ||
        bank_busy[i_pins.bank] > 0)) o_viol <= o_viol + 1;
    if (i_pins.cmd == CMD_CAL_INIT) busy <= 511;
    if (i_pins.cmd == CMD_CAL_LONG) busy <= 255;
    if (i_pins.cmd == CMD_CAL_SHRT) busy <= 63;
    if (i_pins.cmd == CMD_WRITE_AP) bank_busy[i_pins.bank] <= 1;
  end
endmodule : mem_dev_model

// >>> dv/tb.sv
module tb;
  import mem_timing_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic      sys_clk = 1'b0, sys_rst = 1'b1, req_valid = 1'b0;
  logic      pdn_req = 1'b0, sref_req = 1'b0, term_req = 1'b0, b8 = 1'b0;
  mem_req_t  req = '0;
  mem_pins_t pins;
  logic      ready, clk_en, drv_ok, edge_ok;
  int        n_mismatch = 0, tests_run = 0, cyc = 0, last_t = 0, viol;
  mem_cmd_sched i_dut (.I_SYS_CLK(sys_clk), .I_SYS_RST(sys_rst), .I_REQ(req),
    .I_REQ_VALID(req_valid), .I_PDN_REQ(pdn_req), .I_SREF_REQ(sref_req),
    .I_TERM_REQ(term_req), .O_PINS(pins), .O_REQ_READY(ready), .O_CLK_EN(clk_en),
    .O_STROBE_DRV_OK(drv_ok), .O_STROBE_EDGE_OK(edge_ok));
  mem_dev_model i_dev (.i_clk(sys_clk), .i_pins(pins), .o_viol(viol));
  always #20 sys_clk = ~sys_clk;
  // cycle count, with a cut-off well past the longest run
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  task step;
    @(posedge sys_clk);
    #1;
  endtask : step
  task chk(input int got, input int exp, input bit ex);
    tests_run++;
    if (ex ? got != exp : got < exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk
  // four-state compare, so an unknown on a pin counts as a mismatch
  task chkv(input logic [3:0] got, input logic [3:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chkv
  // hold a request until it shows, then judge the gap since the last one
  task send(input mem_cmd_t c, input logic [2:0] b, input logic lk, input int mn,
            input bit ex);
    int n;
    step();
    req = '{cmd: c, bank: b, needs_lock: lk, burst8: b8};
    req_valid = 1'b1;
    n = 0;
    do begin
      step();
      n++;
    end while (ready !== 1'b1 && n < 2000);
    req_valid = 1'b0;
    chkv(pins.cmd, c);
    chkv(4'(pins.bank), 4'(b));
    chk(cyc - last_t, mn, ex);
    last_t = cyc;
  endtask : send
  // enter a low power state, stay a while, leave, then issue one command
  task lowpwr(input bit sr, input logic lk, input int lo, input int mn);
    int n;
    step();
    if (sr) sref_req = 1'b1;
    else pdn_req = 1'b1;
    n = 0;
    while (pins.cke !== 1'b0 && n < 100) begin
      step();
      n++;
    end
    repeat (8) step();
    sref_req = 1'b0;
    pdn_req = 1'b0;
    n = 8;
    while (pins.cke !== 1'b1 && n < 100) begin
      step();
      n++;
    end
    chk(n, lo, 0);
    last_t = cyc;
    send(CMD_REFRESH, 3'h0, lk, mn, 0);
  endtask : lowpwr
  task t_reset;
    int n;
    step();
    chkv(pins.cke, 1'b0);
    chkv(pins.reset_n, 1'b0);
    chkv(clk_en, 1'b1);
    n = 0;
    while (pins.cke !== 1'b1 && n < 200) begin
      step();
      n++;
    end
    last_t = cyc;
  endtask : t_reset
  task t_boot;
    send(CMD_CAL_INIT, 3'h0, 1'b0, 5, 0);
    send(CMD_MODE_SET, 3'h0, 1'b0, 512, 0);
    send(CMD_MODE_SET, 3'h0, 1'b0, 4, 1);
    send(CMD_ACTIVATE, 3'h0, 1'b0, 12, 0);
    send(CMD_ACTIVATE, 3'h1, 1'b0, 4, 1);
    send(CMD_READ, 3'h0, 1'b0, 1, 0);
    send(CMD_READ, 3'h1, 1'b0, 4, 1);
    send(CMD_PRECHG, 3'h1, 1'b0, 4, 0);
    send(CMD_WRITE, 3'h0, 1'b0, 1, 0);
    send(CMD_READ, 3'h0, 1'b0, 4, 0);
    send(CMD_PURPOSE, 3'h0, 1'b0, 1, 0);
    send(CMD_READ, 3'h0, 1'b0, 1, 0);
    send(CMD_WRITE_AP, 3'h2, 1'b0, 4, 0);
    send(CMD_ACTIVATE, 3'h2, 1'b0, 2, 0);
    send(CMD_CAL_LONG, 3'h0, 1'b0, 1, 0);
    send(CMD_ACTIVATE, 3'h3, 1'b0, 256, 0);
    send(CMD_CAL_SHRT, 3'h0, 1'b0, 1, 0);
    send(CMD_ACTIVATE, 3'h4, 1'b0, 64, 0);
  endtask : t_boot
  task t_level;
    int n;
    send(CMD_LEVEL, 3'h0, 1'b0, 1, 0);
    // both flags are low one cycle after ready rises
    step();
    n = 1;
    chkv({2'b00, drv_ok, edge_ok}, 4'h0);
    while (drv_ok !== 1'b1 && n < 100) begin
      step();
      n++;
    end
    chk(n, 25, 0);
    while (edge_ok !== 1'b1 && n < 100) begin
      step();
      n++;
    end
    chk(n, 40, 0);
  endtask : t_level
  task t_pwr;
    lowpwr(1'b0, 1'b0, 3, 3);
    lowpwr(1'b0, 1'b1, 3, 10);
    lowpwr(1'b1, 1'b0, 4, 5);
    lowpwr(1'b1, 1'b1, 4, 512);
  endtask : t_pwr
  task t_term;
    int n;
    step();
    term_req = 1'b1;
    step();
    term_req = 1'b0;
    n = (pins.term_en === 1'b1) ? 1 : 0;
    repeat (12) begin
      step();
      if (pins.term_en === 1'b1) n++;
    end
    chk(n, 4, 0);
    // an 8-beat write issued while termination is asked holds it longer
    term_req = 1'b1;
    b8 = 1'b1;
    send(CMD_WRITE, 3'h5, 1'b0, 1, 0);
    term_req = 1'b0;
    n = (pins.term_en === 1'b1) ? 1 : 0;
    repeat (12) begin
      step();
      if (pins.term_en === 1'b1) n++;
    end
    chk(n, 6, 0);
    chk(viol, 0, 1);
  endtask : t_term
  task end_of_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (3) step();
    sys_rst = 1'b0;
    t_reset();
    t_boot();
    t_level();
    t_pwr();
    t_term();
    end_of_test();
  end
endmodule : tb
bind mem_cmd_sched mem_cmd_sched_sva i_sva (.I_SYS_CLK(I_SYS_CLK), .I_SYS_RST(I_SYS_RST),
  .O_PINS(O_PINS), .O_CLK_EN(O_CLK_EN));
